/* xbre_pkg.sv */
// Purpose : constants for the port crossbar routing enable registers
// Assumes : special-function register bus, one byte per access
// Notes   : field positions and reset values are named once here
package xbre_pkg;
    // ------------------------------------------------------------------
    // register selects on the special-function bus
    // ------------------------------------------------------------------
    localparam logic [1:0] XBRE_SEL_FIRST  = 2'h0;  // first routing register
    localparam logic [1:0] XBRE_SEL_SECOND = 2'h1;  // second routing register
    // ------------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------------
    localparam logic [7:0] XBRE_FIRST_RST  = 8'h00;
    localparam logic [7:0] XBRE_SECOND_RST = 8'h00;
    // bit five of the second register is unused and reads as zero
    localparam logic [7:0] XBRE_SECOND_WMASK = 8'hDF;
    // ------------------------------------------------------------------
    // first register fields
    // ------------------------------------------------------------------
    localparam int XBRE_B_CMP1_OUT  = 0;
    localparam int XBRE_B_T0_IN     = 1;
    localparam int XBRE_B_IRQ0      = 2;
    localparam int XBRE_B_T1_IN     = 3;
    localparam int XBRE_B_IRQ1      = 4;
    localparam int XBRE_B_T2_IN     = 5;
    localparam int XBRE_B_T2_CAP    = 6;
    localparam int XBRE_B_SYSCLK    = 7;
    // ------------------------------------------------------------------
    // second register fields
    // ------------------------------------------------------------------
    localparam int XBRE_B_CNV0      = 0;
    localparam int XBRE_B_EMIF_LOW  = 1;
    localparam int XBRE_B_UART1     = 2;
    localparam int XBRE_B_T4_IN     = 3;
    localparam int XBRE_B_T4_CAP    = 4;
    localparam int XBRE_B_MASTER    = 6;
    localparam int XBRE_B_PULL_OFF  = 7;
endpackage : xbre_pkg

/* xbre_gate.sv */
// Purpose : one registered route gate, enable and master qualify a signal
// Assumes : inputs synchronous to clk_sys_i
// Notes   : idle value is chosen by the parent per signal polarity
`timescale 1ns/10ps
module xbre_gate #(
    parameter int W = 1                  // width of the gated signal
) (
    // clock and reset
    input  wire logic         clk_sys_i,
    input  wire logic         rst_n_i,
    input  wire logic         ce_i,
    // gating
    input  wire logic         en_i,       // route enabled and master on
    input  wire logic [W-1:0] sig_i,      // signal to pass
    input  wire logic [W-1:0] idle_i,     // value when not routed
    input  wire logic [W-1:0] rst_val_i,  // unused at reset; constant used
    output logic      [W-1:0] sig_o
);
    logic [W-1:0] q_reg;
    logic [W-1:0] q_next;
    // next value: pass when routed, else hold the idle level
    always_comb begin
        q_next = q_reg;
        if (ce_i) begin
            q_next = en_i ? sig_i : idle_i;
        end
    end
    // register only; reset to zero, parent reads through polarity
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            q_reg <= '0;
        end else begin
            q_reg <= q_next;
        end
    end
    assign sig_o = q_reg;
    logic unused_ok;
    assign unused_ok = |rst_val_i;
endmodule : xbre_gate

/* xbre_top.sv */
// Purpose : port crossbar routing enable registers and their gating
// Assumes : byte-wide special-function bus, single clock, sync inputs
// Notes   : active-low interrupt inputs idle high when not routed
//           routed signals lag their pins by two clock edges
// What this block does
// - first bit4 routes external interrupt one
// - first bit2 routes external interrupt zero
// - first bit1 routes timer zero count
// - second bit4 routes timer four capture
// - second bit3 routes timer four count
`timescale 1ns/10ps
module xbre_top
    import xbre_pkg::*;
(
    // clock, reset, enable
    input  wire logic       clk_sys_i,
    input  wire logic       rst_n_i,
    input  wire logic       ce_i,
    // special-function register bus
    input  wire logic [1:0] sfr_sel_i,
    input  wire logic       sfr_wr_i,
    input  wire logic [7:0] sfr_wdata_i,
    output logic      [7:0] sfr_rdata_o,
    // pin-side signals
    input  wire logic       ext_irq1_input_n_i,
    input  wire logic       ext_irq0_input_n_i,
    input  wire logic       timer_zero_count_input_i,
    input  wire logic       timer_four_capture_input_i,
    input  wire logic       timer_four_count_input_i,
    // peripheral-side routed signals
    output logic            ext_irq1_n_o,
    output logic            ext_irq0_n_o,
    output logic            timer_zero_count_o,
    output logic            timer_four_capture_o,
    output logic            timer_four_count_o,
    // global controls
    output logic            ports_force_input_o,
    output logic            weak_pullup_disable_o
);
    // ------------------------------------------------------------------
    // register file
    // ------------------------------------------------------------------
    // crossbar_route_enables_first: one routing enable per bit
    logic [7:0] first_reg;
    logic [7:0] first_next;
    // crossbar_route_enables_second: routes plus master and pull-up control
    logic [7:0] second_reg;
    logic [7:0] second_next;
    // read data is registered so the bus sees a flop, one cycle behind select
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;
    // global controls are registered from the second register, the force flag as the inverted master bit
    logic       force_reg;
    logic       force_next;
    logic       wpu_reg;
    logic       wpu_next;

    // writes land directly; reads show the stored bits
    always_comb begin
        first_next  = first_reg;
        second_next = second_reg;
        rdata_next  = rdata_reg;
        force_next  = force_reg;
        wpu_next    = wpu_reg;
        // with ce_i low every value holds, so the whole block freezes
        if (ce_i) begin
            // a write lands at the edge that samples the strobe
            if (sfr_wr_i && sfr_sel_i == XBRE_SEL_FIRST) begin
                first_next = sfr_wdata_i;
            end
            // the unused bit is masked off so it always reads zero
            if (sfr_wr_i && sfr_sel_i == XBRE_SEL_SECOND) begin
                second_next = sfr_wdata_i & XBRE_SECOND_WMASK;
            end
            // read mux shows the stored value, not one being written now
            unique case (sfr_sel_i)
                XBRE_SEL_FIRST:  rdata_next = first_reg;
                XBRE_SEL_SECOND: rdata_next = second_reg;
                2'h2, 2'h3:      rdata_next = 8'h00;  // unmapped reads zero
            endcase
            // pins stay inputs until the master enable is set
            force_next = !second_reg[XBRE_B_MASTER];
            // pull-up disable is passed on as stored
            wpu_next   = second_reg[XBRE_B_PULL_OFF];
        end
    end

    // reset puts the crossbar off, so pins start as inputs; the force
    // flag resets high so no pin can drive before software acts
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            first_reg  <= XBRE_FIRST_RST;
            second_reg <= XBRE_SECOND_RST;
            rdata_reg  <= 8'h00;
            force_reg  <= 1'b1;
            wpu_reg    <= 1'b0;
        end else begin
            first_reg  <= first_next;
            second_reg <= second_next;
            rdata_reg  <= rdata_next;
            force_reg  <= force_next;
            wpu_reg    <= wpu_next;
        end
    end

    // ------------------------------------------------------------------
    // route gating: enable bit qualified by master enable
    // ------------------------------------------------------------------
    // master enable qualifies every route
    logic       master;
    // per-route enables, from bit 4 down: irq1, irq0, t0, t4 capture, t4 count
    logic [4:0] en_vec;
    // pin levels in the same order, interrupts flipped to active high
    logic [4:0] sig_vec;
    // level a route shows while it is not routed
    logic [4:0] idle_vec;
    // output of the gate flop, still in active-high form
    logic [4:0] gated;
    // route enables meet the master bit before the gate flop
    assign master   = second_reg[XBRE_B_MASTER];
    assign en_vec   = {first_reg[XBRE_B_IRQ1], first_reg[XBRE_B_IRQ0],
                       first_reg[XBRE_B_T0_IN], second_reg[XBRE_B_T4_CAP],
                       second_reg[XBRE_B_T4_IN]} & {5{master}};
    // interrupts are held inverted so reset-zero flops idle deasserted
    assign sig_vec  = {~ext_irq1_input_n_i, ~ext_irq0_input_n_i, timer_zero_count_input_i,
                       timer_four_capture_input_i, timer_four_count_input_i};
    // not-routed level in active-high form is zero for every route
    assign idle_vec = 5'h00;

    // the gate flop samples the pins; the master bit closes it as a whole,
    // which repeats the masking above but keeps the gate from being tied off
    xbre_gate #(.W(5)) xbre_gate_inst (
        .clk_sys_i (clk_sys_i),
        .rst_n_i   (rst_n_i),
        .ce_i      (ce_i),
        .en_i      (master),
        .sig_i     (sig_vec & en_vec),
        .idle_i    (idle_vec),
        .rst_val_i (idle_vec),
        .sig_o     (gated)
    );

    // the inverter keeps active-low outputs high when not routed
    // the second flop costs one cycle but makes every output a flop
    logic [4:0] out_reg;
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            out_reg <= 5'h18;
        end else if (ce_i) begin
            out_reg <= {~gated[4], ~gated[3], gated[2:0]};
        end
    end
    // outputs come straight from flops
    assign ext_irq1_n_o          = out_reg[4];
    assign ext_irq0_n_o          = out_reg[3];
    assign timer_zero_count_o    = out_reg[2];
    assign timer_four_capture_o  = out_reg[1];
    assign timer_four_count_o    = out_reg[0];
    assign sfr_rdata_o           = rdata_reg;
    assign ports_force_input_o   = force_reg;
    assign weak_pullup_disable_o = wpu_reg;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    // an unrouted interrupt idles deasserted two edges later
    irq1_blocked_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        ce_i && !en_vec[4] ##1 ce_i ##1 ce_i |-> ext_irq1_n_o)
        else $error("irq1 reached peripheral while not routed");
    irq0_blocked_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        ce_i && !en_vec[3] ##1 ce_i ##1 ce_i |-> ext_irq0_n_o)
        else $error("irq0 reached peripheral while not routed");
    // a routed timer zero input follows its pin two edges later; unrouted timer four inputs read low
    t0_pass_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        ce_i && en_vec[2] ##1 ce_i ##1 ce_i |-> timer_zero_count_o == $past(timer_zero_count_input_i, 2))
        else $error("timer zero count not passed");
    t4cap_blocked_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        ce_i && !en_vec[1] ##1 ce_i ##1 ce_i |-> !timer_four_capture_o)
        else $error("timer four capture leaked");
    t4cnt_blocked_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        ce_i && !en_vec[0] ##1 ce_i ##1 ce_i |-> !timer_four_count_o)
        else $error("timer four count leaked");
    // master off forces the pins to input one edge later
    force_input_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        ce_i && !master |=> ports_force_input_o)
        else $error("ports not forced to input with master off");

    // ------------------------------------------------------------------
    // checks, the route ones built on a shared settle sequence
    // ------------------------------------------------------------------
    // a route state seen with the clock running, then two more running
    // edges: the gate flop and the output flop have both moved by then
    sequence route_settle_s(cond);
        ce_i && cond ##1 ce_i ##1 ce_i;
    endsequence
    // a routed interrupt follows its pin two edges later
    irq1_pass_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        route_settle_s(en_vec[4]) |-> ext_irq1_n_o == $past(ext_irq1_input_n_i, 2))
        else $error("irq1 not passed while routed");
    irq0_pass_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        route_settle_s(en_vec[3]) |-> ext_irq0_n_o == $past(ext_irq0_input_n_i, 2))
        else $error("irq0 not passed while routed");
    // an unrouted timer zero input reads as a quiet low; routed timer four inputs follow their pins two edges later
    t0_blocked_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        route_settle_s(!en_vec[2]) |-> !timer_zero_count_o)
        else $error("timer zero count leaked");
    t4cap_pass_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        route_settle_s(en_vec[1]) |-> timer_four_capture_o == $past(timer_four_capture_input_i, 2))
        else $error("timer four capture not passed");
    t4cnt_pass_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        route_settle_s(en_vec[0]) |-> timer_four_count_o == $past(timer_four_count_input_i, 2))
        else $error("timer four count not passed");
    // master on lets the pins leave input mode one edge later
    force_release_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        ce_i && master |=> !ports_force_input_o)
        else $error("ports still forced to input with master on");
    // master off idles every route whatever its own bit says
    routes_idle_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        route_settle_s(!master) |-> ext_irq1_n_o && ext_irq0_n_o && !timer_zero_count_o
            && !timer_four_capture_o && !timer_four_count_o)
        else $error("a route stayed open with master off");
    // a low clock enable holds both registers, the read data and the routed outputs
    freeze_hold_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        !ce_i |=> $stable(first_reg) && $stable(second_reg) && $stable(out_reg) && $stable(rdata_reg))
        else $error("state moved while clock enable was low");
    // the unused bit of the second register never holds a one
    unused_bit_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        (second_reg & ~XBRE_SECOND_WMASK) == 8'h00)
        else $error("unused bit of second register set");
endmodule : xbre_top

/* xbre_pins.sv */
// Purpose : pin-side stand-in for the five routed input pins
// Assumes : pins are plain levels in the system clock domain
// Notes   : no pull resistors modelled; bench sets every level
`timescale 1ns/10ps
module xbre_pins (
    // pattern from the bench
    input  wire logic [4:0] lvl_i,
    // pin levels toward the block
    output logic      [4:0] pins_o
);
    // pins follow the pattern at once, like a driven board net
    assign pins_o = lvl_i;
endmodule : xbre_pins

/* xbre_top_tb.sv */
// Purpose : self-checking bench for the crossbar routing enables
// Assumes : outputs settle within three cycles of any change
// Notes   : driver queues expectations, a monitor pops and compares
`timescale 1ns/10ps
module xbre_top_tb;
    import xbre_pkg::*;
    logic        clk_sys_i   = 1'b0;
    logic        rst_n_i     = 1'b0;
    logic        ce_i        = 1'b1;
    logic [1:0]  sfr_sel_i   = 2'h0;
    logic        sfr_wr_i    = 1'b0;
    logic [7:0]  sfr_wdata_i = 8'h00;
    logic [4:0]  pin_lvl     = 5'h1F;  // levels handed to the pin model
    logic [4:0]  pins;
    logic [7:0]  rd;
    logic [6:0]  outs;                 // routed outputs and globals
    logic        chk         = 1'b0;   // monitor strobe
    logic [14:0] notes[$];             // expected {rdata, outs}
    logic [14:0] mon_e;                // note taken off by the monitor
    logic [31:0] seed        = 32'h712E;
    int          fails       = 0;
    int          comparisons = 0;
    always #5 clk_sys_i = ~clk_sys_i;
    xbre_pins xbre_pins_inst (.lvl_i(pin_lvl), .pins_o(pins));
    xbre_top xbre_top_inst (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .ce_i(ce_i), .sfr_sel_i(sfr_sel_i),
        .sfr_wr_i(sfr_wr_i), .sfr_wdata_i(sfr_wdata_i), .sfr_rdata_o(rd), .ext_irq1_input_n_i(pins[0]),
        .ext_irq0_input_n_i(pins[1]), .timer_zero_count_input_i(pins[2]), .timer_four_capture_input_i(pins[3]),
        .timer_four_count_input_i(pins[4]), .ext_irq1_n_o(outs[6]), .ext_irq0_n_o(outs[5]),
        .timer_zero_count_o(outs[4]), .timer_four_capture_o(outs[3]), .timer_four_count_o(outs[2]),
        .ports_force_input_o(outs[1]), .weak_pullup_disable_o(outs[0]));
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd
    // routes need their own bit and the master bit; interrupts idle high
    function automatic logic [14:0] expv(logic [7:0] a, logic [7:0] b, logic [4:0] p, logic [7:0] r);
        logic m;
        m = b[XBRE_B_MASTER];
        return {r, (a[XBRE_B_IRQ1] & m) ? p[0] : 1'b1, (a[XBRE_B_IRQ0] & m) ? p[1] : 1'b1,
                a[XBRE_B_T0_IN] & m & p[2], b[XBRE_B_T4_CAP] & m & p[3], b[XBRE_B_T4_IN] & m & p[4],
                ~m, b[XBRE_B_PULL_OFF]};
    endfunction : expv
    task automatic cyc(int n);
        repeat (n) @(posedge clk_sys_i);
    endtask : cyc
    task automatic wr(logic [1:0] s, logic [7:0] d);
        @(posedge clk_sys_i);
        sfr_sel_i   <= s;
        sfr_wr_i    <= 1'b1;
        sfr_wdata_i <= d;
        @(posedge clk_sys_i);
        sfr_wr_i    <= 1'b0;
    endtask : wr
    task automatic note(logic [14:0] e);
        notes.push_back(e);
        @(posedge clk_sys_i);
        chk <= 1'b1;
        @(posedge clk_sys_i);
        chk <= 1'b0;
    endtask : note
    task automatic chk_rd(logic [7:0] got, logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("Error at %0t: read got %h expected %h", $time, got, exp);
        end
    endtask : chk_rd
    task automatic chk_out(logic [6:0] got, logic [6:0] exp);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("Error at %0t: outputs got %h expected %h", $time, got, exp);
        end
    endtask : chk_out
    task automatic do_reset();
        @(posedge clk_sys_i);
        rst_n_i <= 1'b0;
        cyc(20);
        rst_n_i <= 1'b1;
        note(expv(XBRE_FIRST_RST, XBRE_SECOND_RST, 5'h00, 8'h00));
    endtask : do_reset
    task automatic test_done();
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : test_done
    // monitor: each strobe retires the oldest expectation
    always @(posedge clk_sys_i) begin
        if (chk === 1'b1 && notes.size() > 0) begin
            mon_e = notes.pop_front();
            chk_rd(rd, mon_e[14:7]);
            chk_out(outs, mon_e[6:0]);
        end
    end
    // watchdog so a stall still reaches the verdict
    initial begin
        cyc(20000);
        fails++;
        test_done();
    end
    initial begin
        logic [7:0] a;
        logic [7:0] b;
        logic [4:0] p;
        do_reset();
        for (int i = 0; i < 48; i++) begin
            a = 8'(rnd());
            b = 8'(rnd());
            p = 5'(rnd());
            wr({1'b1, a[0]}, ~a);    // unmapped place, must be ignored
            wr(XBRE_SEL_FIRST, a);
            wr(XBRE_SEL_SECOND, b);
            @(posedge clk_sys_i);
            ce_i <= 1'b0;
            wr(XBRE_SEL_FIRST, ~a);  // frozen while ce_i is low
            @(posedge clk_sys_i);
            ce_i      <= 1'b1;
            pin_lvl   <= p;
            sfr_sel_i <= XBRE_SEL_FIRST;
            cyc(4);
            b = b & XBRE_SECOND_WMASK;
            note(expv(a, b, p, a));
            sfr_sel_i <= XBRE_SEL_SECOND;
            cyc(3);
            note(expv(a, b, p, b));
            sfr_sel_i <= {1'b1, p[0]};
            cyc(3);
            note(expv(a, b, p, 8'h00));
        end
        $display("test random routes done");
        do_reset();
        $display("test second reset done");
        cyc(4);
        if (notes.size() != 0) begin
            fails++;
        end
        test_done();
    end
endmodule : xbre_top_tb
